// ---- hw/i2c_fifo_defs.svh ----
`ifndef I2C_FIFO_DEFS_SVH
`define I2C_FIFO_DEFS_SVH

// register bus
`define ADDR_W        8
`define DATA_W        32

// register offsets
`define OFF_RX_DATA   8'h18
`define OFF_TX_THR    8'h1c
`define OFF_RX_THR    8'h20
`define OFF_IRQ_MASK  8'h2c
`define OFF_RAW_STAT  8'h30
`define OFF_CTRL      8'h34
`define OFF_LEVELS    8'h38

// field layout
`define BYTE_W        8
`define LIMIT_W       10
`define LIMIT_MAX     1023
`define BITCNT_W      3
`define BIT_TX_NE     1
`define BIT_RX_NF     5
`define BIT_SLV_WR    18
`define BIT_DMA_EN    0
`define TX_LVL_LSB    16
`define STAT_USED     32'h0004_0022

// reset values and defaults
`define LIMIT_RST     10'h000
`define WORD_RST      32'h0000_0000
`define RX_DEPTH_DEF  16

`endif

// ---- hw/i2c_fifo_pkg.sv ----
`include "i2c_fifo_defs.svh"

package i2c_fifo_pkg;

    typedef logic [`BYTE_W-1:0]   byte_t;
    typedef logic [`LIMIT_W-1:0]  limit_t;
    typedef logic [`DATA_W-1:0]   word_t;
    typedef logic [`ADDR_W-1:0]   addr_t;
    typedef logic [`BITCNT_W-1:0] bitcnt_t;

    function automatic logic reg_hit(input addr_t addr, input addr_t off);
        return addr == off;
    endfunction : reg_hit

endpackage : i2c_fifo_pkg

// ---- hw/rx_byte_fifo.sv ----
`timescale 1ns/10ps

`include "i2c_fifo_defs.svh"

module rx_byte_fifo
    import i2c_fifo_pkg::*;
#(
    parameter int DATA_W = `BYTE_W,
    parameter int DEPTH  = `RX_DEPTH_DEF,
    parameter int CNT_W  = $clog2(DEPTH + 1)
) (
    input  wire logic              sys_clk,
    input  wire logic              arst_n,
    input  wire logic              push_valid,
    input  wire logic [DATA_W-1:0] push_data,
    output logic                   push_ready,
    output logic                   pop_valid,
    output logic      [DATA_W-1:0] pop_data,
    input  wire logic              pop_ready,
    output logic      [CNT_W-1:0]  level
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    generate
        if (DEPTH < 2 || CNT_W < $clog2(DEPTH + 1)) begin : g_bad_depth
            $error("rx_byte_fifo: depth below two or level too narrow");
        end
    endgenerate

    logic [DATA_W-1:0] mem [DEPTH];
    logic [PTR_W-1:0]  wr_ptr;
    logic [PTR_W-1:0]  rd_ptr;
    logic [PTR_W-1:0]  next_wr_ptr;
    logic [PTR_W-1:0]  next_rd_ptr;
    logic [CNT_W-1:0]  next_level;
    logic              push_fire;
    logic              pop_fire;

    assign push_ready  = level != CNT_W'(DEPTH);
    assign pop_valid   = level != '0;
    assign pop_data    = mem[rd_ptr];
    assign push_fire   = push_valid && push_ready;
    assign pop_fire    = pop_ready && pop_valid;
    assign next_wr_ptr = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + PTR_W'(1);
    assign next_rd_ptr = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + PTR_W'(1);
    assign next_level  = level + CNT_W'(push_fire) - CNT_W'(pop_fire);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level  <= '0;
        end else begin
            if (push_fire) begin
                wr_ptr <= next_wr_ptr;
            end
            if (pop_fire) begin
                rd_ptr <= next_rd_ptr;
            end
            level <= next_level;
        end
    end

    // storage carries no reset, contents are don't-care until written
    always_ff @(posedge sys_clk) begin
        if (push_fire) begin
            mem[wr_ptr] <= push_data;
        end
    end

endmodule : rx_byte_fifo

// ---- hw/i2c_fifo_data_thresholds.sv ----
`timescale 1ns/10ps

// How it works
// - read register returns oldest received byte
// - first received bit lands at bit zero
// - hold serial clock low while fifo full
// - slave receive address match sets request flag
// - dma mode requests while fifo holds entries
// - tx nearly empty when count <= limit
// - rx nearly full when count >= limit
// - tx nearly empty reaches irq via mask bit1
// - rx nearly full reaches irq via mask bit5

`include "i2c_fifo_defs.svh"

module i2c_fifo_data_thresholds
    import i2c_fifo_pkg::*;
#(
    parameter int RX_DEPTH = `RX_DEPTH_DEF
) (
    input  wire logic     sys_clk,
    input  wire logic     arst_n,
    input  wire addr_t    addr,
    input  wire word_t    wdata,
    input  wire logic     wr_stb,
    input  wire logic     rd_stb,
    output word_t         rdata,
    input  wire logic     serial_bit,
    input  wire logic     serial_bit_valid,
    input  wire logic     slave_receive_operation,
    input  wire limit_t   tx_level,
    output logic          scl_out,
    output logic          scl_oe,
    output logic          rx_dma_req,
    output logic          tx_nearly_empty_flag,
    output logic          rx_nearly_full_flag,
    output logic          irq
);

    localparam int CNT_W = $clog2(RX_DEPTH + 1);

    generate
        if (RX_DEPTH < 2 || RX_DEPTH > `LIMIT_MAX) begin : g_bad_depth
            $error("rx depth must fit the 10-bit level field");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////

    word_t            tx_fifo_threshold;
    word_t            rx_fifo_threshold;
    word_t            irq_mask;
    word_t            raw_interrupt_status;
    word_t            ctrl;
    word_t            next_rdata;
    word_t            next_stat;
    word_t            stat_set;
    word_t            stat_clr;
    word_t            levels_word;
    limit_t           tx_level_limit;
    limit_t           rx_level_limit;
    limit_t           rx_count;
    logic [CNT_W-1:0] rx_level;
    byte_t            shift;
    byte_t            next_shift;
    byte_t            pend_byte;
    byte_t            pop_data;
    bitcnt_t          bit_cnt;
    logic             pend_valid;
    logic             byte_done;
    logic             bit_take;
    logic             push_ready;
    logic             pop_valid;
    logic             fifo_full;
    logic             dma_en;
    logic             wr_tx_thr;
    logic             wr_rx_thr;
    logic             wr_mask;
    logic             wr_stat;
    logic             wr_ctrl;
    logic             rd_data_hit;
    logic             pop_fire;
    logic             push_fire;

    ////////////////////////////////////////////////////////////////////////////////
    // register decode

    assign wr_tx_thr   = wr_stb && reg_hit(addr, `OFF_TX_THR);
    assign wr_rx_thr   = wr_stb && reg_hit(addr, `OFF_RX_THR);
    assign wr_mask     = wr_stb && reg_hit(addr, `OFF_IRQ_MASK);
    assign wr_stat     = wr_stb && reg_hit(addr, `OFF_RAW_STAT);
    assign wr_ctrl     = wr_stb && reg_hit(addr, `OFF_CTRL);
    assign rd_data_hit = rd_stb && reg_hit(addr, `OFF_RX_DATA);

    assign tx_level_limit = tx_fifo_threshold[`LIMIT_W-1:0];
    assign rx_level_limit = rx_fifo_threshold[`LIMIT_W-1:0];
    assign dma_en         = ctrl[`BIT_DMA_EN];
    assign rx_count       = limit_t'(rx_level);

    assign levels_word = (word_t'(tx_level) << `TX_LVL_LSB) | word_t'(rx_count);

    // reads of an empty fifo return zero and pop nothing
    assign next_rdata =
        rd_data_hit ? (pop_valid ? word_t'(pop_data) : `WORD_RST) :
        !rd_stb ? `WORD_RST :
        reg_hit(addr, `OFF_TX_THR) ? tx_fifo_threshold :
        reg_hit(addr, `OFF_RX_THR) ? rx_fifo_threshold :
        reg_hit(addr, `OFF_IRQ_MASK) ? irq_mask :
        reg_hit(addr, `OFF_RAW_STAT) ? raw_interrupt_status :
        reg_hit(addr, `OFF_CTRL) ? ctrl :
        reg_hit(addr, `OFF_LEVELS) ? levels_word :
        `WORD_RST;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_fifo_threshold <= `WORD_RST;
            rx_fifo_threshold <= `WORD_RST;
            irq_mask          <= `WORD_RST;
            ctrl              <= `WORD_RST;
            rdata             <= `WORD_RST;
        end else begin
            if (wr_tx_thr) begin
                tx_fifo_threshold <= wdata;
            end
            if (wr_rx_thr) begin
                rx_fifo_threshold <= wdata;
            end
            if (wr_mask) begin
                irq_mask <= wdata;
            end
            if (wr_ctrl) begin
                ctrl <= wdata;
            end
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // serial byte assembly

    // bits are shifted in at the top so the first one ends at bit zero
    assign bit_take   = serial_bit_valid && !pend_valid;
    assign next_shift = {serial_bit, shift[`BYTE_W-1:1]};
    assign byte_done  = bit_take && (bit_cnt == bitcnt_t'(`BYTE_W - 1));
    assign push_fire  = pend_valid && push_ready;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            shift      <= '0;
            bit_cnt    <= '0;
            pend_byte  <= '0;
            pend_valid <= 1'b0;
        end else begin
            if (bit_take) begin
                shift   <= next_shift;
                bit_cnt <= bit_cnt + bitcnt_t'(1);
            end
            if (byte_done) begin
                pend_byte  <= next_shift;
                pend_valid <= 1'b1;
            end else if (push_fire) begin
                pend_valid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // receive fifo

    assign pop_fire = rd_data_hit && pop_valid;

    rx_byte_fifo #(
        .DATA_W (`BYTE_W),
        .DEPTH  (RX_DEPTH),
        .CNT_W  (CNT_W)
    ) u_rx_fifo (
        .sys_clk    (sys_clk),
        .arst_n     (arst_n),
        .push_valid (pend_valid),
        .push_data  (pend_byte),
        .push_ready (push_ready),
        .pop_valid  (pop_valid),
        .pop_data   (pop_data),
        .pop_ready  (pop_fire),
        .level      (rx_level)
    );

    assign fifo_full = !push_ready;

    // open drain: only ever pull low, a held byte also keeps the line low
    assign scl_out = 1'b0;
    assign scl_oe  = fifo_full || pend_valid;

    // single requests; the dma answers by reading the data register
    assign rx_dma_req = dma_en && pop_valid;

    ////////////////////////////////////////////////////////////////////////////////
    // thresholds and interrupt

    // limits compare against live counts, so the flags are levels
    assign tx_nearly_empty_flag = tx_level <= tx_level_limit;
    assign rx_nearly_full_flag  = rx_count >= rx_level_limit;

    always_comb begin
        stat_set                = '0;
        stat_set[`BIT_TX_NE]    = tx_nearly_empty_flag;
        stat_set[`BIT_RX_NF]    = rx_nearly_full_flag;
        stat_set[`BIT_SLV_WR]   = slave_receive_operation;
    end

    // set wins over a write-one clear in the same cycle
    assign stat_clr  = wr_stat ? (wdata & `STAT_USED) : `WORD_RST;
    assign next_stat = (raw_interrupt_status & ~stat_clr) | stat_set;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            raw_interrupt_status <= `WORD_RST;
        end else begin
            raw_interrupt_status <= next_stat;
        end
    end

    assign irq = |(raw_interrupt_status & irq_mask & `STAT_USED);

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    logic first_bit;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            first_bit <= 1'b0;
        end else if (bit_take && bit_cnt == '0) begin
            first_bit <= serial_bit;
        end
    end

    a_read_oldest: assert property (
        pop_fire |=> rdata == word_t'($past(pop_data))
    ) else $error("data read did not return the oldest byte");

    a_lsb_first: assert property (
        byte_done |=> pend_byte[0] == first_bit
    ) else $error("first serial bit not at bit zero");

    a_stretch_full: assert property (
        fifo_full |-> scl_oe && !scl_out
    ) else $error("clock not held low while fifo full");

    a_stretch_release: assert property (
        !fifo_full && !pend_valid |-> !scl_oe
    ) else $error("clock held low with room in fifo");

    a_slave_flag: assert property (
        slave_receive_operation |=> raw_interrupt_status[`BIT_SLV_WR]
    ) else $error("slave write request flag not set");

    a_dma_request: assert property (
        dma_en && rx_level != '0 && !pop_fire ##1 dma_en |-> rx_dma_req
    ) else $error("no dma request with entries held");

    a_tx_threshold: assert property (
        tx_level <= tx_level_limit |=> raw_interrupt_status[`BIT_TX_NE]
    ) else $error("tx nearly empty not raised");

    a_rx_threshold: assert property (
        rx_count >= rx_level_limit |=> raw_interrupt_status[`BIT_RX_NF]
    ) else $error("rx nearly full not raised");

    a_tx_irq_gate: assert property (
        raw_interrupt_status[`BIT_TX_NE] && irq_mask[`BIT_TX_NE] |-> irq
    ) else $error("unmasked tx nearly empty gave no irq");

    a_rx_irq_gate: assert property (
        raw_interrupt_status[`BIT_RX_NF] && irq_mask[`BIT_RX_NF] |-> irq
    ) else $error("unmasked rx nearly full gave no irq");

    a_irq_source: assert property (
        irq |-> |(raw_interrupt_status & irq_mask)
    ) else $error("irq without an unmasked status bit");

    a_pop_count: assert property (
        pop_fire && !push_fire |=> rx_level == $past(rx_level) - CNT_W'(1)
    ) else $error("data read did not pop one entry");

    a_rdata_idle: assert property (
        !rd_stb |=> rdata == `WORD_RST
    ) else $error("read data not zero outside a read");

    a_dma_off: assert property (
        !dma_en |-> !rx_dma_req
    ) else $error("dma request outside dma mode");

    c_full_stretch: cover property (fifo_full ##1 !fifo_full);
    c_tx_near_mt:   cover property ($rose(tx_nearly_empty_flag));
    c_slave_req:    cover property (slave_receive_operation ##1 irq);
    c_dma_read:     cover property (rx_dma_req ##1 pop_fire);
    c_rx_near_full: cover property ($rose(rx_nearly_full_flag));

endmodule : i2c_fifo_data_thresholds

// ---- bench/serial_sender.sv ----
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module serial_sender (
    input  wire logic       sys_clk,
    input  wire logic       arst_n,
    input  wire logic       go,
    input  wire logic [7:0] go_byte,
    input  wire logic       scl_oe,
    output logic            serial_bit,
    output logic            serial_bit_valid,
    output logic            busy
);
    logic [7:0] shift;
    logic [3:0] left;

    assign busy = (left != 4'h0);

    ////////////////////////////////////////////////////////////////////////////
    // idle line toggles so a stale bit can never look valid
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            shift            <= 8'h00;
            left             <= 4'h0;
            serial_bit       <= 1'b1;
            serial_bit_valid <= 1'b0;
        end else if (go) begin
            shift            <= go_byte;
            left             <= 4'h8;
            serial_bit_valid <= 1'b0;
        end else if (busy && !scl_oe) begin
            serial_bit       <= shift[0];
            shift            <= {1'b0, shift[7:1]};
            left             <= left - 4'h1;
            serial_bit_valid <= 1'b1;
        end else begin
            serial_bit       <= ~serial_bit;
            serial_bit_valid <= 1'b0;
        end
    end
endmodule : serial_sender

// ---- bench/tb_i2c_fifo_data_thresholds.sv ----
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module tb_i2c_fifo_data_thresholds
    import i2c_fifo_pkg::*;
;
    logic   sys_clk = 1'b0;
    logic   arst_n  = 1'b0;
    addr_t  addr    = 8'h00;
    word_t  wdata   = 32'h0000_0000;
    logic   wr_stb  = 1'b0;
    logic   rd_stb  = 1'b0;
    logic   slv_op  = 1'b0;
    limit_t tx_level = 10'h000;
    logic   go      = 1'b0;
    byte_t  go_byte = 8'h00;
    word_t  rdata;
    logic   sbit, sval, busy, scl_out, scl_oe, rx_dma_req, txne, rxnf, irq;
    int     n_fail = 0;
    int     cmp_count = 0;
    byte_t  seq [5] = '{8'h01, 8'h80, 8'h7e, 8'hc3, 8'h5a};

    always #4 sys_clk = ~sys_clk;

    i2c_fifo_data_thresholds #(.RX_DEPTH(4)) i2c_fifo_data_thresholds_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .serial_bit(sbit),
        .serial_bit_valid(sval), .slave_receive_operation(slv_op),
        .tx_level(tx_level), .scl_out(scl_out), .scl_oe(scl_oe),
        .rx_dma_req(rx_dma_req), .tx_nearly_empty_flag(txne),
        .rx_nearly_full_flag(rxnf), .irq(irq));

    serial_sender serial_sender_i (
        .sys_clk(sys_clk), .arst_n(arst_n), .go(go), .go_byte(go_byte),
        .scl_oe(scl_oe), .serial_bit(sbit), .serial_bit_valid(sval), .busy(busy));

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk_w(input word_t got, input word_t exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_w

    task automatic chk_b(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_b

    task automatic wr(input addr_t a, input word_t d);
        @(posedge sys_clk);
        wr_stb <= 1'b1;
        addr   <= a;
        wdata  <= d;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask : wr

    task automatic rd(input addr_t a, input word_t exp);
        @(posedge sys_clk);
        rd_stb <= 1'b1;
        addr   <= a;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1;
        chk_w(rdata, exp);
    endtask : rd

    // settle n edges, then look at a flag
    task automatic flag(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : flag

    task automatic send(input byte_t b, input int waitn);
        @(posedge sys_clk);
        go      <= 1'b1;
        go_byte <= b;
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (waitn) @(posedge sys_clk);
    endtask : send

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd(8'h1c, 32'h0000_0000);
        rd(8'h20, 32'h0000_0000);
        rd(8'h18, 32'h0000_0000);
        rd(8'h3c, 32'h0000_0000);
        wr(8'h1c, 32'h8000_0005);
        rd(8'h1c, 32'h8000_0005);
        for (int t = 4; t < 7; t++) begin
            @(posedge sys_clk);
            tx_level <= limit_t'(t);
            flag(2);
            chk_b(txne, t <= 5);
        end
        wr(8'h20, 32'h0000_0002);
        wr(8'h30, 32'h0000_0022);
        wr(8'h2c, 32'h0000_0002);
        flag(1);
        chk_b(irq, 1'b0);
        @(posedge sys_clk);
        tx_level <= 10'h005;
        flag(3);
        chk_b(irq, 1'b1);
        @(posedge sys_clk);
        tx_level <= 10'h006;
        // tx bit stays set, so only the mask keeps irq low here
        wr(8'h2c, 32'h0000_0020);
        flag(1);
        chk_b(irq, 1'b0);
        send(8'ha5, 14);
        send(8'h3c, 14);
        chk_b(rxnf, 1'b1);
        chk_b(irq, 1'b1);
        rd(8'h18, 32'h0000_00a5);
        chk_b(rxnf, 1'b0);
        rd(8'h38, 32'h0006_0001);
        wr(8'h30, 32'h0000_0020);
        flag(1);
        chk_b(irq, 1'b0);
        wr(8'h34, 32'h0000_0001);
        flag(1);
        chk_b(rx_dma_req, 1'b1);
        rd(8'h18, 32'h0000_003c);
        chk_b(rx_dma_req, 1'b0);
        wr(8'h34, 32'h0000_0000);
        for (int i = 0; i < 4; i++) send(seq[i], 14);
        send(seq[4], 20);
        chk_b(scl_oe, 1'b1);
        chk_b(scl_out, 1'b0);
        chk_b(busy, 1'b1);
        rd(8'h18, 32'h0000_0001);
        repeat (14) @(posedge sys_clk);
        for (int i = 1; i < 5; i++) rd(8'h18, {24'h0, seq[i]});
        rd(8'h18, 32'h0000_0000);
        rd(8'h38, 32'h0006_0000);
        chk_b(scl_oe, 1'b0);
        wr(8'h2c, 32'h0004_0000);
        @(posedge sys_clk);
        slv_op <= 1'b1;
        @(posedge sys_clk);
        slv_op <= 1'b0;
        flag(2);
        chk_b(irq, 1'b1);
        rd(8'h30, 32'h0004_0022);
        wr(8'h30, 32'h0004_0000);
        flag(1);
        chk_b(irq, 1'b0);
        // reset in mid-run must bring back the idle register state
        @(posedge sys_clk);
        arst_n <= 1'b0;
        flag(1);
        chk_w(rdata, 32'h0000_0000);
        chk_b(irq, 1'b0);
        repeat (2) @(posedge sys_clk);
        arst_n <= 1'b1;
        flag(1);
        chk_b(rxnf, 1'b1);
        chk_b(txne, 1'b0);
        rd(8'h1c, 32'h0000_0000);
        rd(8'h2c, 32'h0000_0000);
        rd(8'h30, 32'h0000_0020);
        tally_and_finish();
    end

    // the run needs well under 1500 cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        tally_and_finish();
    end
endmodule : tb_i2c_fifo_data_thresholds
